// ===== design/tpe_track_output_encoder.sv
// Overview of operation
// - PWM pin always driven, never tri-stated
// - Default mode sends multi-width pulse train
// - Position mode: 50% centre, 25%..75% ends
// - Position mode without tape gives 50%
// - Tape mode: high with tape, low without
// - Code mode: high time 250ms times code
// - Analog position 1.5V centre, 0..3V ends
// - Analog position without tape gives 1.5V
// - Analog tape mode: 3V present, 0V absent
// - Analog code mode: 0.4V times code
// - PWM and analog modes chosen independently
// - Receive pin as input selects track
// - Serial default 115200, 8N, no flow
// - Bit rate changes only with USB attached
// - Position is signed millimetres, zero centred
// - Keep separate left and right positions
// - Single track: left equals right
// - Forks and merges pass positions apart
// - Both positions sent over serial port
// - Track chosen by serial, USB, script
// - Multi-pulse frame repeats every 10ms
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module tpe_track_output_encoder import tpe_pkg::*; #(
  parameter int MULTI_FRAME  = MULTI_FRAME_CYC,
  parameter int POS_PERIOD   = POS_PERIOD_CYC,
  parameter int TAPE_PERIOD  = TAPE_PERIOD_CYC,
  parameter int CODE_STEP    = CODE_STEP_CYC,
  parameter int CODE_PERIOD  = CODE_PERIOD_CYC,
  parameter int MP_BASE      = MP_BASE_CYC,
  parameter int MP_GAP       = MP_GAP_CYC,
  parameter int MP_CODE_STEP = MP_CODE_STEP_CYC,
  parameter int MP_POS_STEP  = MP_POS_STEP_CYC
) (
  input  wire logic        clock,                // 200 MHz clock
  input  wire logic        rst,                  // Async reset
  input  wire logic        psel,                 // APB select
  input  wire logic        penable,              // APB enable
  input  wire logic        pwrite,               // APB write
  input  wire logic [7:0]  paddr,                // APB address
  input  wire logic [31:0] pwdata,               // APB write data
  output logic             pready,               // APB ready
  output logic [31:0]      prdata,               // APB read data
  output logic             pslverr,              // APB error
  input  wire tpe_sample_t sample_in,            // Track capture
  input  wire logic        sample_valid,         // Capture strobe
  input  wire logic        script_sel_valid,     // Script sets track
  input  wire logic        script_sel_right,     // Script track value
  input  wire logic        usb_attached,         // Config host on USB
  input  wire logic        serial_receive_line,  // Receive pin
  output logic             serial_transmit_line, // Transmit pin
  output logic             pwm_out,              // PWM pin
  output logic [11:0]      analog_level_mv       // DAC command, mV
);

  logic        rx_meta_q;
  logic        rx_pin_q;
  logic        usb_meta_q;
  logic        usb_q;
  tpe_sample_t smp_q;
  logic        new_smp_q;
  logic [4:0]  ctrl_q;
  logic [15:0] baud_q;
  logic        track_q;
  logic [2:0]  rep_cnt_q;
  logic [31:0] rep_buf_q;
  logic [31:0] pwm_cnt_q;
  logic [31:0] per_q;
  logic [31:0] a_q;
  logic [31:0] b_q;
  logic [31:0] c_q;
  logic [1:0]  pmode_q;

  tpe_pwm_mode_t      pmode;
  tpe_ana_mode_t      amode;
  logic               pin_cfg;
  logic               sel_right;
  logic [2:0]         code;
  logic signed [15:0] pos_sel;
  logic signed [15:0] raw_mm [2];
  logic signed [15:0] lim_mm [2];
  int                 pos_eff;
  logic [31:0]        nxt_per;
  logic [31:0]        nxt_a;
  logic [31:0]        nxt_b;
  logic [31:0]        nxt_c;
  logic [11:0]        ana_d;
  logic               wr_en;
  logic               rd_take;
  logic [31:0]        rd_data;
  logic               rd_hit;
  logic               rx_valid;
  logic [7:0]         rx_data;
  logic               tx_ready;
  logic               tx_valid;
  logic               rxd_eff;

  function automatic logic signed [15:0] clamp_mm(input logic signed [15:0] v);
    logic signed [15:0] lim;
    lim = 16'(HALF_WIDTH_MM);
    if (v > lim) begin
      return lim;
    end else if (v < -lim) begin
      return -lim;
    end
    return v;
  endfunction

  // Pin synchronisers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_meta_q <= 1'b1;
      rx_pin_q  <= 1'b1;
    end else begin
      rx_meta_q <= serial_receive_line;
      rx_pin_q  <= rx_meta_q;
    end
  end

  // Host-attached level, gates bit-rate writes and is shown in the status register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      usb_meta_q <= 1'b0;
      usb_q      <= 1'b0;
    end else begin
      usb_meta_q <= usb_attached;
      usb_q      <= usb_meta_q;
    end
  end

  // Clamp per track; a single track copies left to right
  assign raw_mm[0] = sample_in.left_mm;
  assign raw_mm[1] = sample_in.split ? sample_in.right_mm : sample_in.left_mm;

  for (genvar t = 0; t < 2; t++) begin : g_clamp
    assign lim_mm[t] = clamp_mm(raw_mm[t]);
  end

  // Left and right positions, always both kept
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      smp_q <= '0;
    end else if (sample_valid) begin
      smp_q          <= sample_in;
      smp_q.left_mm  <= lim_mm[0];
      smp_q.right_mm <= lim_mm[1];
    end
  end

  // Flags the cycle after a capture, when smp_q holds it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      new_smp_q <= 1'b0;
    end else begin
      new_smp_q <= sample_valid;
    end
  end

  assign pmode   = tpe_pwm_mode_t'(ctrl_q[CTRL_PWM_LSB +: 2]);
  assign amode   = tpe_ana_mode_t'(ctrl_q[CTRL_ANA_LSB +: 2]);
  assign pin_cfg = ctrl_q[CTRL_PIN_BIT];
  assign sel_right = pin_cfg ? rx_pin_q : track_q;
  assign code    = {smp_q.right_mark, smp_q.left_mark, smp_q.tape};
  assign pos_sel = sel_right ? smp_q.right_mm : smp_q.left_mm;
  // Without tape the PWM and analog outputs show the centre position; serial report and ADDR_POS keep smp_q
  assign pos_eff = smp_q.tape ? int'(pos_sel) : 0;

  // APB slave, one wait state
  // Read data is loaded in the wait cycle and shown with pready
  assign wr_en   = psel & penable & pwrite & pready;
  assign rd_take = psel & penable & ~pready;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (paddr)
      ADDR_CTRL:   rd_data = {26'h0, track_q, ctrl_q};
      ADDR_BAUD:   rd_data = {16'h0000, baud_q};
      ADDR_STATUS: rd_data = {27'h0, usb_q, sel_right, code};
      ADDR_POS:    rd_data = {smp_q.right_mm, smp_q.left_mm};
      default:     rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= rd_take;
      pslverr <= rd_take & ~rd_hit;
      if (rd_take) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_en && paddr == ADDR_CTRL) begin
      ctrl_q <= pwdata[4:0];
    end
  end

  // Divisors below 16 refused: the receiver needs room for half-bit timing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      baud_q <= BAUD_DIV_RST;
    end else if (wr_en && paddr == ADDR_BAUD && usb_q && pwdata[15:4] != 12'h000) begin
      baud_q <= pwdata[15:0];
    end
  end

  // Track choice: register, serial command, then script
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      track_q <= 1'b0;
    end else if (wr_en && paddr == ADDR_CTRL) begin
      track_q <= pwdata[CTRL_TRACK_BIT];
    end else if (rx_valid && rx_data == CMD_RIGHT) begin
      track_q <= 1'b1;
    end else if (rx_valid && rx_data == CMD_LEFT) begin
      track_q <= 1'b0;
    end else if (script_sel_valid) begin
      track_q <= script_sel_right;
    end
  end

  // Receive pin doubles as the track-select input
  // Receiver then sees an idle line, so no false start bit
  assign rxd_eff = pin_cfg ? 1'b1 : rx_pin_q;

  tpe_uart_rx u_rx (
    .clock (clock),
    .rst   (rst),
    .div   (baud_q),
    .rxd   (rxd_eff),
    .valid (rx_valid),
    .data  (rx_data)
  );

  // Position report: left lo, left hi, right lo, right hi
  // Captures that arrive during a report are dropped, not queued
  assign tx_valid = rep_cnt_q != 3'h0;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rep_cnt_q <= 3'h0;
      rep_buf_q <= 32'h0000_0000;
    end else if (new_smp_q && rep_cnt_q == 3'h0) begin
      rep_cnt_q <= 3'h4;
      rep_buf_q <= {smp_q.right_mm, smp_q.left_mm};
    end else if (tx_valid && tx_ready) begin
      rep_cnt_q <= rep_cnt_q - 3'h1;
      rep_buf_q <= {8'h00, rep_buf_q[31:8]};
    end
  end

  // Line idles high after reset and between bytes
  tpe_uart_tx u_tx (
    .clock (clock),
    .rst   (rst),
    .div   (baud_q),
    .valid (tx_valid),
    .data  (rep_buf_q[7:0]),
    .ready (tx_ready),
    .txd   (serial_transmit_line)
  );

  // Next PWM period and edges, taken at each period start
  // Multi-pulse frame must outlast the code pulse; defaults leave margin
  always_comb begin
    nxt_per = 32'(MULTI_FRAME);
    nxt_a   = 32'h0000_0000;
    nxt_b   = 32'h0000_0000;
    nxt_c   = 32'h0000_0000;
    unique case (pmode)
      PWM_MULTI: begin
        nxt_per = 32'(MULTI_FRAME);
        nxt_a   = 32'(MP_BASE + (pos_eff + HALF_WIDTH_MM) * MP_POS_STEP);
        nxt_b   = 32'(int'(nxt_a) + MP_GAP);
        nxt_c   = 32'(int'(nxt_b) + MP_BASE + int'(code) * MP_CODE_STEP);
      end
      PWM_POSITION: begin
        nxt_per = 32'(POS_PERIOD);
        nxt_a   = 32'(POS_PERIOD / 2 + (pos_eff * (POS_PERIOD / 4)) / HALF_WIDTH_MM);
      end
      PWM_TAPE: begin
        nxt_per = 32'(TAPE_PERIOD);
        nxt_a   = smp_q.tape ? 32'(TAPE_PERIOD) : 32'h0000_0000;
      end
      PWM_CODE: begin
        nxt_per = 32'(CODE_PERIOD);
        nxt_a   = 32'(int'(code) * CODE_STEP);
      end
    endcase
  end

  // Edges change only at a period start; a mode change starts a new period at once and can cut a pulse short
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwm_cnt_q <= 32'h0000_0000;
      per_q     <= 32'(MULTI_FRAME);
      a_q       <= 32'h0000_0000;
      b_q       <= 32'h0000_0000;
      c_q       <= 32'h0000_0000;
      pmode_q   <= 2'h0;
    end else if (pwm_cnt_q >= per_q - 32'h1 || pmode_q != pmode) begin
      pwm_cnt_q <= 32'h0000_0000;
      per_q     <= nxt_per;
      a_q       <= nxt_a;
      b_q       <= nxt_b;
      c_q       <= nxt_c;
      pmode_q   <= pmode;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= (pwm_cnt_q < a_q) || (pwm_cnt_q >= b_q && pwm_cnt_q < c_q);
    end
  end

  // Analog level command
  // Position scales 1500 mV per 80 mm either side of centre
  always_comb begin
    unique case (amode)
      ANA_TAPE: ana_d = smp_q.tape ? 12'(ANA_FULL_MV) : 12'h000;
      ANA_CODE: ana_d = 12'(int'(code) * ANA_CODE_STEP_MV);
      default:  ana_d = 12'(ANA_CENTER_MV + (pos_eff * ANA_CENTER_MV) / HALF_WIDTH_MM);
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      analog_level_mv <= 12'(ANA_CENTER_MV);
    end else begin
      analog_level_mv <= ana_d;
    end
  end
endmodule
`default_nettype wire

// ===== include/tpe_pkg.sv
package tpe_pkg;
  localparam int CLK_HZ     = 200_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  // Times as printed or chosen, in their own units
  localparam int MULTI_FRAME_MS  = 10;
  localparam int POS_PERIOD_MS   = 4;
  localparam int TAPE_PERIOD_MS  = 1;
  localparam int CODE_STEP_MS    = 250;
  localparam int CODE_PERIOD_MS  = 2000;
  localparam int MP_BASE_US      = 500;
  localparam int MP_GAP_US       = 500;
  localparam int MP_POS_STEP_US  = 10;
  localparam int MP_CODE_STEP_US = 500;
  // Derived cycle counts
  localparam int MULTI_FRAME_CYC  = MULTI_FRAME_MS * CYC_PER_MS;
  localparam int POS_PERIOD_CYC   = POS_PERIOD_MS * CYC_PER_MS;
  localparam int TAPE_PERIOD_CYC  = TAPE_PERIOD_MS * CYC_PER_MS;
  localparam int CODE_STEP_CYC    = CODE_STEP_MS * CYC_PER_MS;
  localparam int CODE_PERIOD_CYC  = CODE_PERIOD_MS * CYC_PER_MS;
  localparam int MP_BASE_CYC      = MP_BASE_US * CYC_PER_US;
  localparam int MP_GAP_CYC       = MP_GAP_US * CYC_PER_US;
  localparam int MP_POS_STEP_CYC  = MP_POS_STEP_US * CYC_PER_US;
  localparam int MP_CODE_STEP_CYC = MP_CODE_STEP_US * CYC_PER_US;
  localparam int HALF_WIDTH_MM    = 80;
  // Serial link
  localparam int          BAUD_DEFAULT = 115200;
  localparam logic [15:0] BAUD_DIV_RST = 16'((CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT);
  localparam logic [3:0]  UART_BITS    = 4'hA;
  localparam logic [7:0]  CMD_LEFT     = 8'h4C;
  localparam logic [7:0]  CMD_RIGHT    = 8'h52;
  // Analog levels in millivolts
  localparam int ANA_CENTER_MV    = 1500;
  localparam int ANA_FULL_MV      = 3000;
  localparam int ANA_CODE_STEP_MV = 400;
  // Register map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_BAUD   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_POS    = 8'h0C;
  localparam logic [4:0] CTRL_RST    = 5'h00;
  localparam int CTRL_PWM_LSB   = 0;
  localparam int CTRL_ANA_LSB   = 2;
  localparam int CTRL_PIN_BIT   = 4;
  localparam int CTRL_TRACK_BIT = 5;

  typedef enum logic [1:0] {PWM_MULTI, PWM_POSITION, PWM_TAPE, PWM_CODE} tpe_pwm_mode_t;
  typedef enum logic [1:0] {ANA_POSITION, ANA_TAPE, ANA_CODE, ANA_SPARE} tpe_ana_mode_t;

  typedef struct packed {
    logic               tape;
    logic               left_mark;
    logic               right_mark;
    logic               split;
    logic signed [15:0] left_mm;
    logic signed [15:0] right_mm;
  } tpe_sample_t;
endpackage

// ===== design/tpe_uart_tx.sv
`timescale 1ns/1ps
`default_nettype none
module tpe_uart_tx import tpe_pkg::*; (
  input  wire logic        clock, // System clock
  input  wire logic        rst,   // Async reset
  input  wire logic [15:0] div,   // Cycles per bit
  input  wire logic        valid, // Byte offered
  input  wire logic [7:0]  data,  // Byte
  output logic             ready, // Idle
  output logic             txd    // Line
);
  logic        busy_q;
  logic [15:0] cnt_q;
  logic [3:0]  bit_q;
  logic [8:0]  sh_q;

  assign ready = ~busy_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      cnt_q  <= 16'h0000;
      bit_q  <= 4'h0;
      sh_q   <= 9'h1FF;
      txd    <= 1'b1;
    end else if (!busy_q) begin
      if (valid) begin
        busy_q <= 1'b1;
        cnt_q  <= 16'h0000;
        bit_q  <= 4'h0;
        sh_q   <= {1'b1, data};
        txd    <= 1'b0;
      end
    end else if (cnt_q == div - 16'h0001) begin
      cnt_q <= 16'h0000;
      if (bit_q == UART_BITS - 4'h1) begin
        busy_q <= 1'b0;
      end else begin
        txd   <= sh_q[0];
        sh_q  <= {1'b1, sh_q[8:1]};
        bit_q <= bit_q + 4'h1;
      end
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ===== design/tpe_uart_rx.sv
`timescale 1ns/1ps
`default_nettype none
module tpe_uart_rx import tpe_pkg::*; (
  input  wire logic        clock, // System clock
  input  wire logic        rst,   // Async reset
  input  wire logic [15:0] div,   // Cycles per bit
  input  wire logic        rxd,   // Synchronised line
  output logic             valid, // Byte pulse
  output logic [7:0]       data   // Byte
);
  logic        busy_q;
  logic [15:0] cnt_q;
  logic [3:0]  bit_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      cnt_q  <= 16'h0000;
      bit_q  <= 4'h0;
      data   <= 8'h00;
      valid  <= 1'b0;
    end else begin
      valid <= 1'b0;
      if (!busy_q) begin
        if (!rxd) begin
          busy_q <= 1'b1;
          cnt_q  <= div >> 1;
          bit_q  <= 4'h0;
        end
      end else if (cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
      end else begin
        cnt_q <= div - 16'h0001;
        bit_q <= bit_q + 4'h1;
        if (bit_q == 4'h0) begin
          busy_q <= ~rxd;
        end else if (bit_q < UART_BITS - 4'h1) begin
          data <= {rxd, data[7:1]};
        end else begin
          // Framing error drops the byte
          valid  <= rxd;
          busy_q <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/tpe_track_output_encoder_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tpe_track_output_encoder_asserts import tpe_pkg::*; (
  input wire logic        clock,          // Clock
  input wire logic        rst,            // Reset
  input wire logic        psel,           // Select
  input wire logic        penable,        // Enable
  input wire logic        pwrite,         // Write
  input wire logic [7:0]  paddr,          // Address
  input wire logic [31:0] pwdata,         // Write data
  input wire logic        pready,         // Ready
  input wire logic [31:0] prdata,         // Read data
  input wire logic        pslverr,        // Error
  input wire tpe_sample_t sample_in,      // Capture
  input wire logic        sample_valid,   // Strobe
  input wire logic [11:0] analog_level_mv // Level
);
  logic [1:0] ana_mode_q;
  // Shadow of the analog mode field, taken at the write's completing edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ana_mode_q <= 2'h0;
    end else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL) begin
      ana_mode_q <= pwdata[CTRL_ANA_LSB +: 2];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  apb_one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready missing after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_unmapped_a: assert property (pready |-> pslverr == (paddr > ADDR_POS))
    else $error("error flag wrong for address");
  write_rdata_a: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("write returned data");
  ana_range_a: assert property (analog_level_mv <= 12'(ANA_FULL_MV))
    else $error("analog above full scale");
  ana_tape_a: assert property (ana_mode_q == 2'h1 && sample_valid ##1 !sample_valid
    |-> ##2 analog_level_mv == ($past(sample_in.tape, 3) ? 12'(ANA_FULL_MV) : 12'h000))
    else $error("analog tape level wrong");
  ana_code_a: assert property (ana_mode_q == 2'h2 && sample_valid ##1 !sample_valid
    |-> ##2 analog_level_mv == 12'(ANA_CODE_STEP_MV) * {$past(sample_in.right_mark, 3),
    $past(sample_in.left_mark, 3), $past(sample_in.tape, 3)})
    else $error("analog code level wrong");
  ana_notape_a: assert property (ana_mode_q inside {2'h0, 2'h3} && sample_valid && !sample_in.tape
    ##1 !sample_valid |-> ##2 analog_level_mv == 12'(ANA_CENTER_MV))
    else $error("analog not centred without tape");
endmodule
bind tpe_track_output_encoder tpe_track_output_encoder_asserts i_chk (.clock, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .sample_in, .sample_valid, .analog_level_mv);
`default_nettype wire

// ===== bench/tpe_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tpe_host_model (
  input  wire logic        clock,   // Clock
  input  wire logic [15:0] div,     // Cycles per bit
  input  wire logic        txd,     // Sensor transmit line
  output logic             rxd,     // Sensor receive line
  output logic [7:0]       rx_byte, // Byte received
  output logic             rx_valid // Byte pulse
);
  initial begin
    rxd = 1'b1;
    rx_byte = 8'h00;
    rx_valid = 1'b0;
  end
  task automatic set_level(input logic b);
    rxd <= b;
  endtask
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (div) @(posedge clock);
    end
  endtask
  // Sample mid-bit; a low stop bit drops the byte
  always begin
    @(negedge txd);
    repeat (div / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge clock);
      rx_byte[i] <= txd;
    end
    repeat (div) @(posedge clock);
    rx_valid <= txd;
    @(posedge clock);
    rx_valid <= 1'b0;
  end
endmodule
`default_nettype wire

// ===== bench/tb_track_position_output_encoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_track_position_output_encoder import tpe_pkg::*; ();
  localparam int PP = 800;
  localparam int TP = 100;
  localparam int CS = 200;
  localparam int CP = 2000;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  tpe_sample_t sample_in = '0;
  logic        sample_valid = 1'b0;
  logic        script_sel_valid = 1'b0;
  logic        script_sel_right = 1'b0;
  logic        usb_attached = 1'b0;
  logic        serial_receive_line;
  logic        serial_transmit_line;
  logic        pwm_out;
  logic [11:0] analog_level_mv;
  logic [15:0] baud_div = BAUD_DIV_RST;
  logic [7:0]  hb;
  logic        hv;
  logic [15:0] rs = 16'h0041;
  logic [31:0] q_rd[$];
  logic [7:0]  q_ser[$];
  int          fails = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          mm;
  tpe_track_output_encoder #(.MULTI_FRAME(4000), .POS_PERIOD(PP), .TAPE_PERIOD(TP), .CODE_STEP(CS),
    .CODE_PERIOD(CP), .MP_BASE(200), .MP_GAP(200), .MP_CODE_STEP(200), .MP_POS_STEP(2)) i_dut (.clock, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .sample_in, .sample_valid,
    .script_sel_valid, .script_sel_right, .usb_attached, .serial_receive_line, .serial_transmit_line,
    .pwm_out, .analog_level_mv);
  tpe_host_model i_host (.clock, .div(baud_div), .txd(serial_transmit_line), .rxd(serial_receive_line),
    .rx_byte(hb), .rx_valid(hv));
  always #2.5 clock = ~clock;
  function automatic logic [15:0] rnd();
    rs = rs ^ (rs << 7);
    rs = rs ^ (rs >> 9);
    rs = rs ^ (rs << 8);
    return rs;
  endfunction
  task automatic note(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic cmp_rd(input logic [31:0] s);
    note("register read", q_rd.size() ? q_rd.pop_front() : 32'hX, s);
  endtask
  task automatic cmp_ser(input logic [7:0] s);
    note("serial byte", q_ser.size() ? 32'(q_ser.pop_front()) : 32'hX, 32'(s));
  endtask
  task automatic cmp_out(input logic [31:0] e, input logic [31:0] s);
    note("output level", e, s);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // Each capture is reported as left then right, low byte first
  task automatic put(input logic t, l, r, sp, input int lm, rm);
    logic [31:0] w;
    sample_in <= '{t, l, r, sp, 16'(lm), 16'(rm)};
    sample_valid <= 1'b1;
    @(posedge clock);
    sample_valid <= 1'b0;
    w = {16'(sp ? rm : lm), 16'(lm)};
    for (int i = 0; i < 4; i++) q_ser.push_back(w[8*i +: 8]);
    for (int i = 0; i < 2000 && q_ser.size() > 0; i++) @(posedge clock);
    note("serial bytes left", 32'h0, 32'(q_ser.size()));
    q_ser.delete();
    repeat (8) @(posedge clock);
  endtask
  task automatic meas(input int per, input int exp);
    int n;
    n = 0;
    repeat (per) @(posedge clock);
    repeat (per) begin
      @(posedge clock);
      n += int'(pwm_out === 1'b1);
    end
    cmp_out(32'(exp), 32'(n));
  endtask
  always @(posedge clock) begin
    cyc++;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      cmp_rd(prdata);
    end
    if (hv === 1'b1) begin
      cmp_ser(hb);
    end
    if (cyc == 100000) begin
      fails++;
      $display("timeout");
      report_and_stop();
    end
  end
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    cmp_out(32'(ANA_CENTER_MV), 32'(analog_level_mv));
    rd(ADDR_BAUD, 32'(BAUD_DIV_RST));
    apb(1'b1, ADDR_BAUD, 32'h10);
    rd(ADDR_BAUD, 32'(BAUD_DIV_RST));
    usb_attached <= 1'b1;
    repeat (4) @(posedge clock);
    apb(1'b1, ADDR_BAUD, 32'h10);
    baud_div <= 16'h0010;
    usb_attached <= 1'b0;
    repeat (4) @(posedge clock);
    rd(ADDR_BAUD, 32'h10);
    rd(8'h10, 32'h0);
    $display("bit rate test done");
    apb(1'b1, ADDR_CTRL, 32'h08);
    for (int c = 0; c < 8; c++) begin
      put(c[0], c[1], c[2], 1'b0, c[0] ? 16 : 0, 5);
      cmp_out(32'(ANA_CODE_STEP_MV * c), 32'(analog_level_mv));
    end
    apb(1'b1, ADDR_CTRL, 32'h04);
    for (int t = 0; t < 2; t++) begin
      put(t[0], 1'b0, 1'b0, 1'b0, 0, 0);
      cmp_out(32'(t * ANA_FULL_MV), 32'(analog_level_mv));
    end
    apb(1'b1, ADDR_CTRL, 32'h00);
    for (int i = 0; i < 6; i++) begin
      mm = i < 2 ? (i ? HALF_WIDTH_MM : -HALF_WIDTH_MM) : 16 * (int'(rnd() % 16'h000B) - 5);
      put(1'b1, 1'b0, 1'b0, 1'b0, mm, -mm);
      cmp_out(32'(ANA_CENTER_MV + mm * ANA_CENTER_MV / HALF_WIDTH_MM), 32'(analog_level_mv));
    end
    apb(1'b1, ADDR_CTRL, 32'h0C);
    put(1'b0, 1'b0, 1'b0, 1'b0, 0, 0);
    cmp_out(32'(ANA_CENTER_MV), 32'(analog_level_mv));
    $display("analog test done");
    apb(1'b1, ADDR_CTRL, 32'h01);
    put(1'b1, 1'b0, 1'b0, 1'b0, HALF_WIDTH_MM, 0);
    meas(PP, PP * 3 / 4);
    put(1'b1, 1'b0, 1'b0, 1'b0, -HALF_WIDTH_MM, 0);
    meas(PP, PP / 4);
    put(1'b0, 1'b0, 1'b0, 1'b0, 0, 0);
    meas(PP, PP / 2);
    apb(1'b1, ADDR_CTRL, 32'h02);
    put(1'b1, 1'b0, 1'b0, 1'b0, 0, 0);
    meas(TP, TP);
    put(1'b0, 1'b0, 1'b0, 1'b0, 0, 0);
    meas(TP, 0);
    apb(1'b1, ADDR_CTRL, 32'h03);
    put(1'b1, 1'b1, 1'b1, 1'b0, 32, 0);
    meas(CP, 7 * CS);
    cmp_out(32'(ANA_CENTER_MV + 32 * ANA_CENTER_MV / HALF_WIDTH_MM), 32'(analog_level_mv));
    put(1'b1, 1'b0, 1'b1, 1'b0, 32, 0);
    meas(CP, 5 * CS);
    put(1'b0, 1'b0, 1'b0, 1'b0, 0, 0);
    meas(CP, 0);
    apb(1'b1, ADDR_CTRL, 32'h00);
    put(1'b1, 1'b1, 1'b0, 1'b0, 16, 0);
    meas(4000, 200 + (16 + HALF_WIDTH_MM) * 2 + 200 + 3 * 200);
    $display("pwm test done");
    apb(1'b1, ADDR_CTRL, 32'h00);
    i_host.send_byte(CMD_RIGHT);
    repeat (8) @(posedge clock);
    rd(ADDR_CTRL, 32'h20);
    put(1'b1, 1'b0, 1'b0, 1'b1, -48, 32);
    cmp_out(32'(ANA_CENTER_MV + 32 * ANA_CENTER_MV / HALF_WIDTH_MM), 32'(analog_level_mv));
    i_host.send_byte(CMD_LEFT);
    repeat (8) @(posedge clock);
    rd(ADDR_CTRL, 32'h00);
    script_sel_right <= 1'b1;
    script_sel_valid <= 1'b1;
    @(posedge clock);
    script_sel_valid <= 1'b0;
    repeat (4) @(posedge clock);
    rd(ADDR_CTRL, 32'h20);
    apb(1'b1, ADDR_CTRL, 32'h10);
    for (int p = 0; p < 2; p++) begin
      i_host.set_level(p[0]);
      repeat (8) @(posedge clock);
      put(1'b1, 1'b0, 1'b0, 1'b1, -48, 32);
      mm = p ? 32 : -48;
      cmp_out(32'(ANA_CENTER_MV + mm * ANA_CENTER_MV / HALF_WIDTH_MM), 32'(analog_level_mv));
    end
    $display("track select test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
